// ===== sdb_core.sv
/*
  Separate-port burst-of-four memory core: one shared address bus, a
  write data port, a read data port and an echo clock pair. It assumes the
  system clock runs well above the link clocks so every link edge is seen.
*/
`timescale 1ns/1ps
`default_nettype none

module sdb_core
  import sdb_pkg::*;
#(
  parameter int WORD_W = sdb_pkg::WORD_W_DFLT,
  parameter int ADDR_W = sdb_pkg::ADDR_W_DFLT
) (
  // System clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset,
  // Link control and shared address
  input  wire sdb_pkg::sdb_ctl_t i_ctl,
  input  wire logic [ADDR_W-1:0] i_addr,
  // Write data port
  input  wire logic [WORD_W-1:0] i_wdata,
  // Read data port and echo clocks
  output logic      [WORD_W-1:0] o_rdata,
  output logic                   o_rd_valid,
  output var sdb_pkg::sdb_echo_t o_echo_clock_out
);

  localparam int SYNC_W = $bits(sdb_ctl_t) + ADDR_W + WORD_W;
  localparam int LINE_W = BURST_LEN * WORD_W;

  sdb_ctl_t          ctl_s;
  logic [ADDR_W-1:0] addr_s;
  logic [WORD_W-1:0] wdata_s;

  // Every pin except reset is registered twice before any logic looks at it
  sdb_sync #(.W(SYNC_W)) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_d       ({i_ctl, i_addr, i_wdata}),
    .o_q       ({ctl_s, addr_s, wdata_s})
  );

  // Edge finding on the sampled link clocks
  logic k_prev;
  logic kn_prev;
  logic k_rise;
  logic kn_rise;
  logic slot_wr;
  logic next_k_prev;
  logic next_kn_prev;
  logic next_slot_wr;
  // Synchroniser reads 0 in reset; idle-high k_n would fake a rise until refilled
  logic [2:0] settle;
  logic [2:0] next_settle;

  assign k_rise  = ctl_s.k & ~k_prev & settle[2];
  assign kn_rise = ctl_s.k_n & ~kn_prev & settle[2];

  always_comb begin
    next_k_prev  = ctl_s.k;
    next_kn_prev = ctl_s.k_n;
    next_slot_wr = slot_wr;
    next_settle  = {settle[1:0], 1'b1};
    if (k_rise) begin
      next_slot_wr = ~slot_wr;
    end
    if (i_reset) begin
      next_k_prev  = 1'b0;
      next_kn_prev = 1'b0;
      next_slot_wr = SLOT_RST;
      next_settle  = 3'h0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    k_prev  <= next_k_prev;
    kn_prev <= next_kn_prev;
    slot_wr <= next_slot_wr;
    settle  <= next_settle;
  end

  logic rd_take;
  logic wr_take;
  assign rd_take = k_rise & ~slot_wr & ~ctl_s.rd_sel_n;
  assign wr_take = k_rise & slot_wr & ~ctl_s.wr_sel_n;

  // Array: one wide line of four words per location
  logic [LINE_W-1:0] mem [0:(2**ADDR_W)-1];

  // Write path
  logic              wr_busy;
  logic [1:0]        wr_beat;
  logic [ADDR_W-1:0] wr_addr;
  logic [LINE_W-1:0] wr_line;
  logic              wr_commit;
  logic              next_wr_busy;
  logic [1:0]        next_wr_beat;
  logic [ADDR_W-1:0] next_wr_addr;
  logic [LINE_W-1:0] next_wr_line;
  logic              next_wr_commit;
  logic              wr_edge;

  // Beats alternate: even words on true rises, odd words on complementary
  assign wr_edge = wr_busy & (wr_beat[0] ? kn_rise : k_rise);

  always_comb begin
    next_wr_busy   = wr_busy;
    next_wr_beat   = wr_beat;
    next_wr_addr   = wr_addr;
    next_wr_line   = wr_line;
    next_wr_commit = 1'b0;
    if (wr_edge) begin
      next_wr_line[wr_beat*WORD_W +: WORD_W] = wdata_s;
      next_wr_beat = wr_beat + 2'h1;
      if (wr_beat == BEAT_LAST) begin
        next_wr_busy   = 1'b0;
        next_wr_commit = 1'b1;
      end
    end else if (wr_take) begin
      next_wr_busy                      = 1'b1;
      next_wr_addr                      = addr_s;
      next_wr_line[0 +: WORD_W]         = wdata_s;
      next_wr_beat                      = BEAT_FIRST + 2'h1;
    end
    if (i_reset) begin
      next_wr_busy   = 1'b0;
      next_wr_beat   = BEAT_RST;
      next_wr_addr   = '0;
      next_wr_line   = '0;
      next_wr_commit = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    wr_busy   <= next_wr_busy;
    wr_beat   <= next_wr_beat;
    wr_addr   <= next_wr_addr;
    wr_line   <= next_wr_line;
    wr_commit <= next_wr_commit;
  end

  // Self-timed array write, no strobe from the controller
  always_ff @(posedge i_clk_sys) begin
    if (wr_commit) begin
      mem[wr_addr] <= wr_line;
    end
  end

  // Read path: a pending slot and a running burst, independent of writes
  logic              rd_pend;
  logic [1:0]        rd_cnt;
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_busy;
  logic [1:0]        rd_beat;
  logic [LINE_W-1:0] rd_line;
  logic              next_rd_pend;
  logic [1:0]        next_rd_cnt;
  logic [ADDR_W-1:0] next_rd_addr;
  logic              next_rd_busy;
  logic [1:0]        next_rd_beat;
  logic [LINE_W-1:0] next_rd_line;
  logic [WORD_W-1:0] next_rdata;
  logic              next_rd_valid;
  sdb_echo_t         next_echo;
  logic              rd_start;
  logic              rd_edge;
  logic [LINE_W-1:0] fetch_line;

  assign rd_start = rd_pend & k_rise & (rd_cnt == 2'h1);
  assign rd_edge  = rd_busy & (rd_beat[0] ? kn_rise : k_rise);
  // Uncommitted write to the same location is newer than the array
  assign fetch_line = (wr_commit && wr_addr == rd_addr) ? wr_line : mem[rd_addr];

  always_comb begin
    next_rd_pend  = rd_pend;
    next_rd_cnt   = rd_cnt;
    next_rd_addr  = rd_addr;
    next_rd_busy  = rd_busy;
    next_rd_beat  = rd_beat;
    next_rd_line  = rd_line;
    next_rdata    = o_rdata;
    next_rd_valid = o_rd_valid;
    next_echo     = '{clk: ctl_s.k, clk_n: ctl_s.k_n};
    if (rd_pend && k_rise) begin
      next_rd_cnt = rd_cnt - 2'h1;
    end
    if (rd_start) begin
      next_rd_pend  = 1'b0;
      next_rd_busy  = 1'b1;
      next_rd_line  = fetch_line;
      next_rdata    = fetch_line[0 +: WORD_W];
      next_rd_valid = 1'b1;
      next_rd_beat  = BEAT_FIRST + 2'h1;
    end else if (rd_edge) begin
      next_rdata   = rd_line[rd_beat*WORD_W +: WORD_W];
      next_rd_beat = rd_beat + 2'h1;
      if (rd_beat == BEAT_LAST) begin
        next_rd_busy = 1'b0;
      end
    end else if (!rd_busy && k_rise) begin
      next_rd_valid = 1'b0;
    end
    // A new read may be taken on the very edge that launches the last one
    if (rd_take) begin
      next_rd_pend = 1'b1;
      next_rd_cnt  = RD_LAT_K;
      next_rd_addr = addr_s;
    end
    if (i_reset) begin
      next_rd_pend  = 1'b0;
      next_rd_cnt   = 2'h0;
      next_rd_addr  = '0;
      next_rd_busy  = 1'b0;
      next_rd_beat  = BEAT_RST;
      next_rd_line  = '0;
      next_rdata    = '0;
      next_rd_valid = 1'b0;
      next_echo     = '0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    rd_pend          <= next_rd_pend;
    rd_cnt           <= next_rd_cnt;
    rd_addr          <= next_rd_addr;
    rd_busy          <= next_rd_busy;
    rd_beat          <= next_rd_beat;
    rd_line          <= next_rd_line;
    o_rdata          <= next_rdata;
    o_rd_valid       <= next_rd_valid;
    o_echo_clock_out <= next_echo;
  end

  // Checking helpers
  logic [2:0] lat_k;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || rd_take) begin
      lat_k <= 3'h0;
    end else if (k_rise && lat_k != 3'h7) begin
      lat_k <= lat_k + 3'h1;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  a_slot_alternate: assert property (k_rise |=> slot_wr != $past(slot_wr))
    else $error("address slot did not alternate");
  a_read_latency: assert property (rd_start |-> lat_k == 3'h1 && !slot_wr)
    else $error("read launched at wrong clock edge");
  a_burst_four: assert property (rd_start |=> rd_busy && rd_beat == 2'h1)
    else $error("burst did not begin at word zero");
  a_ddr_beat: assert property (rd_busy && kn_rise && rd_beat[0] |=> rd_beat == $past(rd_beat) + 2'h1)
    else $error("complementary rise did not advance read beat");
  a_launch_edge: assert property (o_rdata != $past(o_rdata) |-> $past(k_rise || kn_rise))
    else $error("read data changed off a link clock rise");
  a_self_commit: assert property (wr_commit |-> $past(wr_beat) == BEAT_LAST && !wr_busy)
    else $error("array write without four captured words");
  a_deselect_read: assert property (k_rise && !slot_wr && ctl_s.rd_sel_n && !rd_pend |=> !rd_pend)
    else $error("deselected read slot was taken");
  a_newest_data: assert property (wr_commit |=> mem[$past(wr_addr)] == $past(wr_line))
    else $error("committed line missing from array");
  a_echo_follow: assert property (##1 o_echo_clock_out.clk == $past(ctl_s.k))
    else $error("echo clock not following true clock");

endmodule : sdb_core

`default_nettype wire

// ===== sdb_pkg.sv
/*
  Shared constants and carrier types for the separate-port burst-of-four
  static memory core. It assumes a single system clock that samples the
  link clocks as ordinary inputs.
*/
package sdb_pkg;

  // Organisation defaults: word width 18 or 36, locations per array
  localparam int WORD_W_DFLT = 36;
  localparam int ADDR_W_DFLT = 19;
  localparam int BURST_LEN   = 4;
  localparam int SYNC_STAGES = 2;

  // Beat positions inside one burst
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_LAST  = 2'h3;

  // Read latency counted in rising edges of the true link clock
  localparam logic [1:0] RD_LAT_K = 2'h2;

  // Values after reset
  localparam logic [1:0] BEAT_RST = 2'h0;
  localparam logic       SLOT_RST = 1'b0;

  // Link control pins, sampled together
  typedef struct packed {
    logic k;
    logic k_n;
    logic rd_sel_n;
    logic wr_sel_n;
  } sdb_ctl_t;

  // Echo clock pair driven beside the read data
  typedef struct packed {
    logic clk;
    logic clk_n;
  } sdb_echo_t;

endpackage : sdb_pkg

// ===== sdb_sync.sv
/*
  Two-stage synchroniser for a bundle of pins. It assumes every bit is
  independent or is only used when a sampled clock edge says it is stable.
*/
`timescale 1ns/1ps
`default_nettype none

module sdb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset,
  // Pins in, sampled copy out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // First stage is read by the second stage only
  always_comb begin
    next_meta = i_reset ? '0 : i_d;
    next_q    = i_reset ? '0 : meta;
  end

  always_ff @(posedge i_clk_sys) begin
    meta <= next_meta;
    o_q  <= next_q;
  end

endmodule : sdb_sync

`default_nettype wire

// ===== sdb_ctlr_model.sv
/*
  Memory controller model: link clocks, port selects, address, write data.
  Assumes the bench calls op back to back, so the link clock keeps running.
*/
`timescale 1ns/1ps
`default_nettype none

module sdb_ctlr_model #(
  parameter int W = 18,
  parameter int A = 6
) (
  // Pins toward the memory
  output var sdb_pkg::sdb_ctl_t   o_ctl,
  output var logic [A-1:0]        o_addr,
  output var logic [W-1:0]        o_wdata,
  // Read port seen back
  input  wire logic [W-1:0]       i_rdata,
  input  wire logic               i_rd_valid,
  input  wire sdb_pkg::sdb_echo_t i_echo
);
  import sdb_pkg::*;
  logic [W-1:0]   s_d [0:255];
  logic           s_v [0:255];
  logic [1:0]     s_e [0:255];
  int             n_edge = 0;
  logic [2*W-1:0] pend   = '0;
  logic           pend_v = 1'b0;

  initial begin
    // k low, k_n high, both ports deselected
    o_ctl   = 4'h7;
    o_addr  = '0;
    o_wdata = '0;
  end

  // Half link period; pins move mid-phase, clear of both edges
  task automatic step(input logic [A-1:0] a, input logic rs_n, input logic ws_n, input logic dv,
                      input logic [W-1:0] d);
    #31.25;
    o_addr         = a;
    o_ctl.rd_sel_n = rs_n;
    o_ctl.wr_sel_n = ws_n;
    // Idle data bus flips so a stale word cannot pass for a beat
    o_wdata        = dv ? d : ~o_wdata;
    #18.75;
    if (n_edge > 0) begin
      s_d[n_edge-1] = i_rdata;
      s_v[n_edge-1] = i_rd_valid;
      s_e[n_edge-1] = i_echo;
    end
    #12.5;
    o_ctl.k   = ~o_ctl.k;
    o_ctl.k_n = ~o_ctl.k_n;
    n_edge++;
  endtask : step

  // One read slot then one write slot; last two write words ride the next op
  task automatic op(input logic rd, input logic [A-1:0] ra, input logic wr, input logic [A-1:0] wa,
                    input logic [4*W-1:0] wd, output int e);
    e = n_edge;
    // Deselected slots still carry address and data, so an ignored select shows
    step(ra, ~rd, 1'b1, pend_v, pend[W-1:0]);
    step(~o_addr, 1'b1, 1'b1, pend_v, pend[2*W-1:W]);
    step(wa, 1'b1, ~wr, 1'b1, wd[W-1:0]);
    step(~o_addr, 1'b1, 1'b1, 1'b1, wd[2*W-1:W]);
    pend   = wd[4*W-1:2*W];
    pend_v = wr;
  endtask : op
endmodule : sdb_ctlr_model

`default_nettype wire

// ===== testbench.sv
/*
  Self-checking bench for the burst-of-four core at word width 18.
  Assumes the controller model keeps read and write slots alternating.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import sdb_pkg::*;
  localparam int W = 18;
  localparam int A = 6;
  logic           i_clk_sys = 1'b0;
  logic           i_reset   = 1'b1;
  sdb_ctl_t       ctl;
  logic [A-1:0]   addr;
  logic [W-1:0]   wdata;
  logic [W-1:0]   rdata;
  logic           rd_valid;
  sdb_echo_t      echo;
  logic [4*W-1:0] mem [0:63];
  int             error_cnt  = 0;
  int             n_compared = 0;
  int             cyc        = 0;

  always #5 i_clk_sys = ~i_clk_sys;

  sdb_core #(.WORD_W(W), .ADDR_W(A)) u_dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_ctl(ctl), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(rdata), .o_rd_valid(rd_valid), .o_echo_clock_out(echo));
  sdb_ctlr_model #(.W(W), .A(A)) u_ctl (
    .o_ctl(ctl), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata), .i_rd_valid(rd_valid),
    .i_echo(echo));

  task automatic stop_test();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  // Each word tagged with index so a misordered beat shows
  function automatic logic [4*W-1:0] mk_line(input logic [A-1:0] a, input logic [3:0] s);
    logic [4*W-1:0] l;
    for (int i = 0; i < 4; i++) begin
      l[i*W +: W] = {s, a, 2'(i), ~a};
    end
    return l;
  endfunction : mk_line

  // Expected read value is taken before this op's own write lands
  task automatic go(input logic rd, input logic [A-1:0] ra, input logic wr, input logic [A-1:0] wa,
                    input logic [3:0] s, output int e, output logic [4*W-1:0] exp);
    exp = mem[ra];
    u_ctl.op(rd, ra, wr, wa, mk_line(wa, s), e);
    if (wr) begin
      mem[wa] = mk_line(wa, s);
    end
  endtask : go

  task automatic idle2();
    int             e;
    logic [4*W-1:0] x;
    repeat (2) go(1'b0, 6'h00, 1'b0, 6'h00, 4'h0, e, x);
  endtask : idle2

  // Word 0 at the second k rise after the read slot, then one per edge
  task automatic chk_read(input int e, input logic [4*W-1:0] exp);
    for (int i = 0; i < 4; i++) begin
      chk_bit("rd_valid", 1'b1, u_ctl.s_v[e+4+i]);
      chk_word("rdata", exp[i*W +: W], u_ctl.s_d[e+4+i]);
    end
  endtask : chk_read

  task automatic t_idle();
    idle2();
    for (int i = 0; i < 7; i++) begin
      chk_bit("rd_valid idle", 1'b0, u_ctl.s_v[i]);
      chk_bit("echo clk", ~i[0], u_ctl.s_e[i][1]);
      chk_bit("echo clk_n", i[0], u_ctl.s_e[i][0]);
    end
  endtask : t_idle

  task automatic t_write_read();
    int             e0;
    int             e1;
    logic [4*W-1:0] x0;
    logic [4*W-1:0] x1;
    go(1'b0, 6'h00, 1'b1, 6'h05, 4'h1, e0, x0);
    go(1'b0, 6'h00, 1'b1, 6'h3f, 4'h2, e0, x0);
    go(1'b1, 6'h05, 1'b0, 6'h00, 4'h0, e0, x0);
    go(1'b1, 6'h3f, 1'b0, 6'h00, 4'h0, e1, x1);
    idle2();
    chk_read(e0, x0);
    chk_read(e1, x1);
    chk_bit("rd_valid end", 1'b0, u_ctl.s_v[e1+8]);
  endtask : t_write_read

  task automatic t_concurrent();
    int             e0;
    int             e1;
    logic [4*W-1:0] x0;
    logic [4*W-1:0] x1;
    go(1'b1, 6'h05, 1'b1, 6'h0a, 4'h3, e0, x0);
    go(1'b1, 6'h0a, 1'b0, 6'h00, 4'h0, e1, x1);
    idle2();
    chk_read(e0, x0);
    chk_read(e1, x1);
  endtask : t_concurrent

  task automatic t_coherent();
    int             e;
    logic [4*W-1:0] x;
    go(1'b0, 6'h00, 1'b1, 6'h05, 4'h4, e, x);
    go(1'b1, 6'h05, 1'b0, 6'h00, 4'h0, e, x);
    idle2();
    chk_read(e, x);
  endtask : t_coherent

  task automatic t_deselect();
    int             e;
    logic [4*W-1:0] x;
    go(1'b0, 6'h00, 1'b0, 6'h0a, 4'h5, e, x);
    go(1'b1, 6'h0a, 1'b0, 6'h00, 4'h0, e, x);
    idle2();
    chk_read(e, x);
  endtask : t_deselect

  // About 520 cycles expected; the ceiling leaves wide margin
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  initial begin
    repeat (16) @(posedge i_clk_sys);
    chk_bit("rd_valid reset", 1'b0, rd_valid);
    chk_word("rdata reset", '0, rdata);
    #1 i_reset = 1'b0;
    repeat (4) @(posedge i_clk_sys);
    t_idle();
    t_write_read();
    t_concurrent();
    t_coherent();
    t_deselect();
    stop_test();
  end
endmodule : testbench

`default_nettype wire
